//--- pmcs_pkg.sv
// Constants, field layout and carrier types for the power-state block.
// Assumes a PCI configuration access port clocked with the block.
package pmcs_pkg;

  // Register placement: default capability start, and register offset from it
  localparam logic [7:0] PMCS_CSR_OFFSET  = 8'h04;
  localparam logic [7:0] PMCS_CAP_PTR_DEF = 8'h40;

  // Field positions within power_state_control_status, and the D3cold index into the support bits
  localparam int PMCS_STAT_BIT   = 15;
  localparam int PMCS_SCALE_HI   = 14;
  localparam int PMCS_SCALE_LO   = 13;
  localparam int PMCS_SEL_HI     = 12;
  localparam int PMCS_SEL_LO     = 9;
  localparam int PMCS_EN_BIT     = 8;
  localparam int PMCS_PS_HI      = 1;
  localparam int PMCS_PS_LO      = 0;
  localparam int PMCS_D3COLD_IDX = 4;

  // Byte lanes holding the register
  localparam int PMCS_LANE_HI = 1;
  localparam int PMCS_LANE_LO = 0;

  // Reset values and the strap synchroniser wait count
  localparam logic [1:0]  PMCS_SCALE_RST = 2'h0;
  localparam logic [3:0]  PMCS_SEL_RST   = 4'h0;
  localparam logic [31:0] PMCS_ZERO_WORD = 32'h0000_0000;
  localparam logic [1:0]  PMCS_SYNC_DONE = 2'h2;

  // Power state encoding
  typedef enum logic [1:0] {
    PMCS_D0    = 2'b00,
    PMCS_D1    = 2'b01,
    PMCS_D2    = 2'b10,
    PMCS_D3HOT = 2'b11
  } pmcs_pwr_e;

  // One configuration access, byte address and lanes
  typedef struct packed {
    logic [7:0]  addr;
    logic [3:0]  be;
    logic        wr;
    logic        rd;
    logic [31:0] wdata;
  } pmcs_cfg_req_s;

endpackage

//--- pmcs_strap_capture.sv
// Catches the amber port-4 strap once after power-on reset.
// Assumes the strap pin is asynchronous and static after power-up.
module pmcs_strap_capture (
  // Clock and power-on reset
  input  wire logic clk_in,
  input  wire logic por_n_in,
  // Strap pin
  input  wire logic port4_amber_strap_pin_in,
  // Captured level
  output logic      strap_level_out,
  output logic      strap_valid_out
);
  import pmcs_pkg::*;

  logic       sync1_reg, sync2_reg;
  logic [1:0] cnt_reg, cnt_next;
  logic       lvl_reg, lvl_next;
  logic       val_reg, val_next;

  always_comb begin
    cnt_next = cnt_reg;
    lvl_next = lvl_reg;
    val_next = val_reg;
    if (!por_n_in) begin
      cnt_next = 2'h0;
      lvl_next = 1'b0;
      val_next = 1'b0;
    end else if (!val_reg) begin
      // Wait until the synchroniser holds a real pin sample
      if (cnt_reg == PMCS_SYNC_DONE) begin
        lvl_next = sync2_reg;
        val_next = 1'b1;
      end else begin
        cnt_next = cnt_reg + 2'h1;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    sync1_reg <= port4_amber_strap_pin_in;
    sync2_reg <= sync1_reg;
    cnt_reg   <= cnt_next;
    lvl_reg   <= lvl_next;
    val_reg   <= val_next;
  end

  assign strap_level_out = lvl_reg;
  assign strap_valid_out = val_reg;

endmodule

//--- pmcs_power_ctrl.sv
// Power-management control/status register of one PCI function.
// Assumes config accesses arrive as one-cycle requests on the PCI clock;
// por_n_in falls only at power-up, rst_n_in is the PCI bus reset.
module pmcs_power_ctrl
#(
  parameter logic [7:0] CAP_PTR      = pmcs_pkg::PMCS_CAP_PTR_DEF,
  parameter logic       D1_SUPPORT   = 1'b1,
  parameter logic       D2_SUPPORT   = 1'b1,
  parameter logic [3:0] WAKE_SUP_LOW = 4'hF,
  parameter logic       DATA_IMPL    = 1'b0
) (
  // Clock and resets
  input  wire logic                    clk_in,
  input  wire logic                    rst_n_in,
  input  wire logic                    por_n_in,
  // Configuration access
  input  wire pmcs_pkg::pmcs_cfg_req_s cfg_req_in,
  output logic [31:0]                  cfg_rdata_out,
  output logic                         cfg_ack_out,
  // Function events and strap
  input  wire logic                    wake_event_in,
  input  wire logic                    port4_amber_strap_pin_in,
  // Wake pin, open drain
  output logic                         pme_o_out,
  output logic                         pme_oe_out,
  // State seen by the function
  output logic [1:0]                   power_state_out,
  output logic [4:0]                   wake_support_per_state_out
);
  import pmcs_pkg::*;

  function automatic logic state_ok(input logic [1:0] st);
    unique case (pmcs_pwr_e'(st))
      PMCS_D1: state_ok = D1_SUPPORT;
      PMCS_D2: state_ok = D2_SUPPORT;
      PMCS_D0,
      PMCS_D3HOT: state_ok = 1'b1;
    endcase
  endfunction

  // sticky bits outlive a bus reset only with D3cold wake
  function automatic logic keep_sticky(input logic rst_n,
                                       input logic d3cold_sup);
    keep_sticky = rst_n | d3cold_sup;
  endfunction

  // Only the dword is compared; byte enables pick the lanes
  localparam logic [5:0] CSR_DWORD =
    6'((CAP_PTR + PMCS_CSR_OFFSET) >> 2);

  // Decoded access and live support bits
  logic        strap_lvl;
  logic        strap_val;
  logic        req;
  logic        hit;
  logic        wr_hi;
  logic        wr_lo;
  logic [1:0]  ps_wr;
  logic [4:0]  sup;
  logic [15:0] csr;

  // Register state and next values, one group per always_ff
  pmcs_pwr_e   ps_reg;
  pmcs_pwr_e   ps_next;
  logic        stat_reg;
  logic        stat_next;
  logic        en_reg;
  logic        en_next;
  logic        oe_reg;
  logic        oe_next;
  logic [3:0]  sel_reg;
  logic [3:0]  sel_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic        ack_reg;
  logic        ack_next;
  logic [4:0]  sup_reg;
  logic [4:0]  sup_next;

  pmcs_strap_capture u_strap (
    .clk_in                   (clk_in),
    .por_n_in                 (por_n_in),
    .port4_amber_strap_pin_in (port4_amber_strap_pin_in),
    .strap_level_out          (strap_lvl),
    .strap_valid_out          (strap_val)
  );

  // per-state support bits, D3cold from the strap
  assign sup = {strap_val & strap_lvl, WAKE_SUP_LOW};

  always_comb begin
    sup_next = sup;
  end

  always_ff @(posedge clk_in) begin
    sup_reg <= sup_next;
  end

  assign req   = cfg_req_in.rd | cfg_req_in.wr;
  assign hit   = (cfg_req_in.addr[7:2] == CSR_DWORD);
  assign wr_hi = hit & cfg_req_in.wr & cfg_req_in.be[PMCS_LANE_HI];
  assign wr_lo = hit & cfg_req_in.wr & cfg_req_in.be[PMCS_LANE_LO];
  assign ps_wr = cfg_req_in.wdata[PMCS_PS_HI:PMCS_PS_LO];

  // scale reads zero, select zero unless implemented
  always_comb begin
    csr = 16'h0000;
    csr[PMCS_STAT_BIT] = stat_reg;
    csr[PMCS_SCALE_HI:PMCS_SCALE_LO] = PMCS_SCALE_RST;
    csr[PMCS_SEL_HI:PMCS_SEL_LO] = DATA_IMPL ? sel_reg : PMCS_SEL_RST;
    csr[PMCS_EN_BIT] = en_reg;
    csr[PMCS_PS_HI:PMCS_PS_LO] = ps_reg;
  end

  // every access outside bus reset acked next cycle; unmapped reads give zero
  always_comb begin
    ack_next   = req;
    rdata_next = PMCS_ZERO_WORD;
    if (cfg_req_in.rd && hit) begin
      rdata_next = {16'h0000, csr};
    end
    if (!rst_n_in) begin
      ack_next   = 1'b0;
      rdata_next = PMCS_ZERO_WORD;
    end
  end

  always_ff @(posedge clk_in) begin
    ack_reg   <= ack_next;
    rdata_reg <= rdata_next;
  end

  // Power state group
  always_comb begin
    ps_next = ps_reg;
    if (wr_lo && state_ok(ps_wr)) begin
      ps_next = pmcs_pwr_e'(ps_wr);
    end
    if (!rst_n_in) begin
      ps_next = PMCS_D0;
    end
  end

  always_ff @(posedge clk_in) begin
    ps_reg <= ps_next;
  end

  // select stored only when the data register exists
  always_comb begin
    sel_next = sel_reg;
    if (wr_hi && DATA_IMPL) begin
      sel_next = cfg_req_in.wdata[PMCS_SEL_HI:PMCS_SEL_LO];
    end
    if (!rst_n_in) begin
      sel_next = PMCS_SEL_RST;
    end
  end

  always_ff @(posedge clk_in) begin
    sel_reg <= sel_next;
  end

  // Wake group: sticky bits and the open-drain enable
  always_comb begin
    stat_next = stat_reg;
    en_next   = en_reg;
    // only enable and the clear bit are taken from lane 1
    if (wr_hi) begin
      en_next = cfg_req_in.wdata[PMCS_EN_BIT];
    end
    if (wr_hi && cfg_req_in.wdata[PMCS_STAT_BIT]) begin
      stat_next = 1'b0;
    end
    // event sets status, set beats clear
    if (wake_event_in && sup[ps_reg]) begin
      stat_next = 1'b1;
    end
    // bus reset clears them unless D3cold wake is supported
    if (!keep_sticky(rst_n_in, sup[PMCS_D3COLD_IDX])) begin
      stat_next = 1'b0;
      en_next   = 1'b0;
    end
    // Power-on gives a defined value where the bits would be unknown
    if (!por_n_in) begin
      stat_next = 1'b0;
      en_next   = 1'b0;
    end
    // drive while status and enable, enable gates
    oe_next = stat_next & en_next;
  end

  always_ff @(posedge clk_in) begin
    stat_reg <= stat_next;
    en_reg   <= en_next;
    oe_reg   <= oe_next;
  end

  // The wake pin only ever pulls low; its level is fixed

  assign cfg_rdata_out              = rdata_reg;
  assign cfg_ack_out                = ack_reg;
  assign pme_o_out                  = 1'b0;
  assign pme_oe_out                 = oe_reg;
  assign power_state_out            = ps_reg;
  assign wake_support_per_state_out = sup_reg;

endmodule

//--- pmcs_power_ctrl_props.sv
// Port checker for the power-state control/status block.
// Assumes default parameters and a bind from the bench top.
module pmcs_power_ctrl_props
  import pmcs_pkg::*;
(
  // Clock and resets
  input wire logic          clk_in,
  input wire logic          rst_n_in,
  input wire logic          por_n_in,
  // Access and events
  input wire pmcs_cfg_req_s cfg_req_in,
  input wire logic [31:0]   cfg_rdata_out,
  input wire logic          cfg_ack_out,
  input wire logic          wake_event_in,
  // Outputs watched
  input wire logic          pme_o_out,
  input wire logic          pme_oe_out,
  input wire logic [1:0]    power_state_out,
  input wire logic [4:0]    wake_support_per_state_out
);
  localparam logic [7:0] CSR = PMCS_CAP_PTR_DEF + PMCS_CSR_OFFSET;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in || !por_n_in);
  wire logic req = cfg_req_in.rd || cfg_req_in.wr;
  wire logic csr_hit = cfg_req_in.addr[7:2] == CSR[7:2];
  wire logic csr_wr = cfg_req_in.wr && csr_hit;
  sequence s_read;
    cfg_req_in.rd && !cfg_req_in.wr ##1 cfg_ack_out;
  endsequence
  sequence s_read_csr;
    cfg_req_in.rd && !cfg_req_in.wr && csr_hit ##1 cfg_ack_out;
  endsequence
  a_ack_follows: assert property (req |=> cfg_ack_out)
    else $error("no ack after request");
  a_ack_idle: assert property (!req |=> !cfg_ack_out)
    else $error("ack without request");
  a_rdata_idle: assert property (
    !cfg_ack_out |-> cfg_rdata_out == 32'h0)
    else $error("read data outside ack");
  a_read_fields: assert property (s_read |->
    cfg_rdata_out[31:16] == 16'h0 && cfg_rdata_out[14:9] == 6'h0
    && cfg_rdata_out[7:2] == 6'h0)
    else $error("fixed fields not zero");
  a_read_state: assert property (s_read_csr |->
    cfg_rdata_out[1:0] == power_state_out)
    else $error("read state differs");
  a_state_write: assert property (csr_wr && cfg_req_in.be[0] |=>
    power_state_out == $past(cfg_req_in.wdata[1:0]))
    else $error("state write lost");
  a_state_hold: assert property (!cfg_req_in.wr |=>
    $stable(power_state_out))
    else $error("state moved without write");
  a_pme_clear: assert property (csr_wr && cfg_req_in.be[1]
    && cfg_req_in.wdata[15] && !wake_event_in |-> ##[1:2] !pme_oe_out)
    else $error("wake pin kept after clear");
  a_oe_steady: assert property (!wake_event_in && !csr_wr |=>
    $stable(pme_oe_out))
    else $error("wake pin moved without cause");
  a_pme_odrain: assert property (pme_o_out == 1'b0)
    else $error("wake pin driven high");
  a_sup_low: assert property (wake_support_per_state_out[3:0] == 4'hF)
    else $error("low support bits wrong");
endmodule

//--- tb.sv
// Self-checking bench for pmcs_power_ctrl with a reference model.
// Assumes default parameters: every state supported, no data register.
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin err_count++; \
  $display("unexpected at %0t: got %h exp %h", $time, a, b); end end
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import pmcs_pkg::*;
  localparam logic [7:0] CSR = PMCS_CAP_PTR_DEF + PMCS_CSR_OFFSET;
  logic clk_in, rst_n_in, por_n_in, wake_event_in, port4_amber_strap_pin_in;
  pmcs_cfg_req_s cfg_req_in;
  logic [31:0] cfg_rdata_out;
  logic cfg_ack_out, pme_o_out, pme_oe_out;
  logic [1:0] power_state_out;
  logic [4:0] wake_support_per_state_out;
  int err_count, compares, n, st, sts, en;
  bit [31:0] seed = 20884;
  pmcs_power_ctrl i_pmcs_power_ctrl (.clk_in, .rst_n_in, .por_n_in,
    .cfg_req_in, .cfg_rdata_out, .cfg_ack_out, .wake_event_in,
    .port4_amber_strap_pin_in, .pme_o_out, .pme_oe_out, .power_state_out,
    .wake_support_per_state_out);
  function automatic bit [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic summarize();
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Model updates at the taking edge; set wins over a same-cycle clear
  task automatic op(bit w, bit r, logic [7:0] a, logic [15:0] d, bit ev);
    logic [31:0] exp;
    exp = {16'h0, sts[0], 6'h0, en[0], 6'h0, st[1:0]};
    @(posedge clk_in);
    cfg_req_in <= '{a, 4'hF, w, r, {16'h0, d}};
    wake_event_in <= ev;
    @(posedge clk_in);
    cfg_req_in <= '0;
    wake_event_in <= 1'b0;
    if (w && a == CSR) begin
      st = d[1:0];
      en = d[8];
      if (d[15]) sts = 0;
    end
    if (ev) sts = 1;
    @(negedge clk_in);
    `CHK(cfg_ack_out, 1'b1)
    if (r) `CHK(cfg_rdata_out, a == CSR ? exp : 32'h0)
    `CHK(power_state_out, st[1:0])
    `CHK(pme_oe_out, sts[0] & en[0])
  endtask
  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end
  // Cut a hang short well past the expected run length
  initial begin
    #40000;
    err_count++;
    summarize();
  end
  initial begin
    {rst_n_in, por_n_in, wake_event_in, cfg_req_in} = '0;
    port4_amber_strap_pin_in = 1'b1;
    repeat (8) @(posedge clk_in);
    rst_n_in <= 1'b1;
    por_n_in <= 1'b1;
    repeat (6) @(negedge clk_in);
    `CHK(wake_support_per_state_out, 5'h1F)
    for (n = 0; n < 4; n++) begin
      op(1, 0, CSR, 16'(n), 0);
      op(0, 1, CSR, 16'h0, 0);
    end
    $display("test states done");
    // Reserved bits written as zero, other fields random
    for (n = 0; n < 60; n++) op(n[0], !n[0], CSR, 16'(rnd() & 32'hFF03),
      rnd() % 4 == 0);
    $display("test random done");
    op(1, 0, 8'h48, 16'hFFFF, 0);
    op(0, 1, 8'h48, 16'h0, 0);
    $display("test unmapped done");
    op(1, 0, CSR, 16'h0103, 1);
    @(posedge clk_in);
    rst_n_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    rst_n_in <= 1'b1;
    st = 0;
    op(0, 1, CSR, 16'h0, 0);
    $display("test bus reset done");
    // Power-on with the strap pulled down: wake bits lose stickiness
    @(posedge clk_in);
    port4_amber_strap_pin_in <= 1'b0;
    rst_n_in <= 1'b0;
    por_n_in <= 1'b0;
    repeat (8) @(posedge clk_in);
    rst_n_in <= 1'b1;
    por_n_in <= 1'b1;
    st = 0;
    sts = 0;
    en = 0;
    repeat (6) @(negedge clk_in);
    `CHK(wake_support_per_state_out, 5'h0F)
    op(1, 0, CSR, 16'h0100, 1);
    @(posedge clk_in);
    rst_n_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    rst_n_in <= 1'b1;
    sts = 0;
    en = 0;
    op(0, 1, CSR, 16'h0, 0);
    $display("test power-on done");
    summarize();
  end
endmodule
bind pmcs_power_ctrl pmcs_power_ctrl_props i_pmcs_power_ctrl_props (.clk_in,
  .rst_n_in, .por_n_in, .cfg_req_in, .cfg_rdata_out, .cfg_ack_out,
  .wake_event_in, .pme_o_out, .pme_oe_out, .power_state_out,
  .wake_support_per_state_out);
